// file: rtl/status_event_pkg.sv
// Types of the status and event reporting block
`include "status_event_reporting_params.svh"

package status_event_pkg;

	typedef logic [`WORD_W-1:0] word_t;

	typedef enum logic [1:0] {
		GRP_OPER_E  = `GRP_OPER,
		GRP_QUES_E  = `GRP_QUES,
		GRP_POWER_E = `GRP_POWER,
		GRP_NONE_E  = `GRP_NONE
	} group_t;

	typedef enum logic [2:0] {
		REG_COND_E   = `REG_COND,
		REG_PTR_E    = `REG_PTR,
		REG_NTR_E    = `REG_NTR,
		REG_EVENT_E  = `REG_EVENT,
		REG_ENABLE_E = `REG_ENABLE
	} reg_sel_t;

endpackage

// file: rtl/status_event_reporting.sv
// Operation, questionable and power status groups with clear-on-read events
//
// Operation
// - Operation condition is read-only and mirrors live state as a weighted sum.
// - Each group has positive and negative transition masks written as sums.
// - Enabled condition transitions set and hold event bits.
// - Reading an event register returns it, then clears it.
// - Operation enable mask gates events onto status byte bit 7.
// - Querying an enable mask returns the last value written.
// - Questionable enable mask gates events onto status byte bit 3.
// - Questionable condition bits come from lower group summaries only.
// - Questionable bit 3 carries the power group summary.
// - Questionable bit 5 carries the frequency group summary.
// - Power bit 0 set while reverse power protection tripped.
// - Power bit 1 set while generator output unleveled.
// - Power bit 2 set while generator oscillator unleveled.
// - Power bit 3 set while main oscillator unleveled.
// - Power bit 4 set while 50 MHz reference unleveled.
// - Power bit 6 set while input overload protection tripped.
// - Power bit 8 set while first oscillator output unleveled, external mixing only.
// - Power bits 5, 7 and 9 to 15 read zero.
// - Questionable condition query returns the weighted sum of set bits.
// - Power group has own masks, clear-on-read events, enable; feeds questionable.
`timescale 1ns/1ps
`include "status_event_reporting_params.svh"

module status_event_reporting
	import status_event_pkg::*;
(
	input  wire logic     clk,
	input  wire logic     rst,
	input  wire word_t    oper_cond_in,
	input  wire logic     rpp_tripped,
	input  wire logic     src_unleveled,
	input  wire logic     src_lo_unleveled,
	input  wire logic     lo_unleveled,
	input  wire logic     ref50_unleveled,
	input  wire logic     input_ovl_tripped,
	input  wire logic     lo_out_unleveled,
	input  wire logic     ext_mix_fitted,
	input  wire logic     freq_summary,
	input  wire logic     cal_summary,
	input  wire logic     integ_summary,
	input  wire logic     cmd_valid,
	input  wire logic     cmd_write,
	input  wire group_t   cmd_group,
	input  wire reg_sel_t cmd_reg,
	input  wire word_t    cmd_wdata,
	output logic          rsp_valid,
	output word_t         rsp_data,
	output logic          oper_summary,
	output logic          ques_summary
);

////////////////////////////////////////////////////////////////////////////////
// Condition sources

	wire [`WORD_W-1:0] cond_q [0:`NUM_GRP-1];
	wire [`WORD_W-1:0] prev_q [0:`NUM_GRP-1];
	wire [`WORD_W-1:0] ptr_q  [0:`NUM_GRP-1];
	wire [`WORD_W-1:0] ntr_q  [0:`NUM_GRP-1];
	wire [`WORD_W-1:0] en_q   [0:`NUM_GRP-1];
	wire [`WORD_W-1:0] ev_q   [0:`NUM_GRP-1];
	wire [`WORD_W-1:0] set_q  [0:`NUM_GRP-1];
	wire               sum_q  [0:`NUM_GRP-1];

	word_t pwr_cond;
	word_t ques_cond;

	always_comb begin
		pwr_cond                  = 16'h0000;
		pwr_cond[`PWR_RPP_BIT]    = rpp_tripped;
		pwr_cond[`PWR_SRC_BIT]    = src_unleveled;
		pwr_cond[`PWR_SRC_LO_BIT] = src_lo_unleveled;
		pwr_cond[`PWR_LO_BIT]     = lo_unleveled;
		pwr_cond[`PWR_REF50_BIT]  = ref50_unleveled;
		pwr_cond[`PWR_IN_OVL_BIT] = input_ovl_tripped;
		// Flag is meaningless without the mixer, so it is held off
		pwr_cond[`PWR_LO_OUT_BIT] = lo_out_unleveled & ext_mix_fitted;
	end

	// Only summaries of lower groups reach this word
	always_comb begin
		ques_cond                  = 16'h0000;
		ques_cond[`QUES_POWER_BIT] = sum_q[`GRP_POWER];
		ques_cond[`QUES_FREQ_BIT]  = freq_summary;
		ques_cond[`QUES_CAL_BIT]   = cal_summary;
		ques_cond[`QUES_INTEG_BIT] = integ_summary;
	end

	assign cond_q[`GRP_OPER]  = oper_cond_in & `OPER_DEF_MASK;
	assign cond_q[`GRP_QUES]  = ques_cond & `QUES_DEF_MASK;
	assign cond_q[`GRP_POWER] = pwr_cond & `PWR_DEF_MASK;

////////////////////////////////////////////////////////////////////////////////
// Per-group filter, event and enable registers

	genvar g;
	generate
		for (g = 0; g < `NUM_GRP; g = g + 1) begin : grp
			word_t ptr_ff;
			word_t ntr_ff;
			word_t en_ff;
			word_t ev_ff;
			word_t prev_ff;
			word_t nxt_ptr;
			word_t nxt_ntr;
			word_t nxt_en;
			word_t nxt_ev;
			word_t nxt_prev;
			word_t rise;
			word_t fall;
			logic  sel;
			logic  wr;
			logic  rd_ev;

			always_comb begin
				sel   = cmd_valid && (cmd_group == group_t'(g));
				wr    = sel && cmd_write;
				rd_ev = sel && !cmd_write && (cmd_reg == REG_EVENT_E);
				rise  = cond_q[g] & ~prev_ff;
				fall  = ~cond_q[g] & prev_ff;
				nxt_prev = cond_q[g];
				nxt_ptr  = ptr_ff;
				nxt_ntr  = ntr_ff;
				nxt_en   = en_ff;
				if (wr && cmd_reg == REG_PTR_E) begin
					nxt_ptr = cmd_wdata;
				end
				if (wr && cmd_reg == REG_NTR_E) begin
					nxt_ntr = cmd_wdata;
				end
				if (wr && cmd_reg == REG_ENABLE_E) begin
					nxt_en = cmd_wdata;
				end
				// Clear first, then new events, so a set wins
				nxt_ev = rd_ev ? `EVENT_RESET : ev_ff;
				nxt_ev = nxt_ev | (rise & ptr_ff) | (fall & ntr_ff);
			end

			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					ptr_ff  <= `PTR_RESET;
					ntr_ff  <= `NTR_RESET;
					en_ff   <= `ENABLE_RESET;
					ev_ff   <= `EVENT_RESET;
					prev_ff <= `PREV_RESET;
				end else begin
					ptr_ff  <= nxt_ptr;
					ntr_ff  <= nxt_ntr;
					en_ff   <= nxt_en;
					ev_ff   <= nxt_ev;
					prev_ff <= nxt_prev;
				end
			end

			assign ptr_q[g]  = ptr_ff;
			assign ntr_q[g]  = ntr_ff;
			assign en_q[g]   = en_ff;
			assign ev_q[g]   = ev_ff;
			assign prev_q[g] = prev_ff;
			assign set_q[g]  = (rise & ptr_ff) | (fall & ntr_ff);
			// Combinational so a mask write shows one cycle later, together with en_ff
			assign sum_q[g]  = |(ev_ff & en_ff);
		end
	endgenerate

	assign oper_summary = sum_q[`GRP_OPER];
	assign ques_summary = sum_q[`GRP_QUES];

////////////////////////////////////////////////////////////////////////////////
// Query answers

	word_t nxt_rsp_data;
	logic  nxt_rsp_valid;
	word_t rsp_data_ff;
	logic  rsp_valid_ff;
	word_t rd_word;

	always_comb begin
		rd_word = 16'h0000;
		if (cmd_group == GRP_NONE_E) begin
			rd_word = 16'h0000;
		end else if (cmd_reg == REG_COND_E) begin
			rd_word = cond_q[cmd_group];
		end else if (cmd_reg == REG_PTR_E) begin
			rd_word = ptr_q[cmd_group];
		end else if (cmd_reg == REG_NTR_E) begin
			rd_word = ntr_q[cmd_group];
		end else if (cmd_reg == REG_EVENT_E) begin
			rd_word = ev_q[cmd_group];
		end else if (cmd_reg == REG_ENABLE_E) begin
			rd_word = en_q[cmd_group];
		end
		nxt_rsp_valid = cmd_valid && !cmd_write;
		nxt_rsp_data  = nxt_rsp_valid ? rd_word : rsp_data_ff;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rsp_valid_ff <= 1'b0;
			rsp_data_ff  <= `RSP_RESET;
		end else begin
			rsp_valid_ff <= nxt_rsp_valid;
			rsp_data_ff  <= nxt_rsp_data;
		end
	end

	assign rsp_valid = rsp_valid_ff;
	assign rsp_data  = rsp_data_ff;

////////////////////////////////////////////////////////////////////////////////
// Checks

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	sequence s_read(logic [1:0] grp, logic [2:0] rsel);
		cmd_valid && !cmd_write && cmd_group == grp && cmd_reg == rsel;
	endsequence

	sequence s_write(logic [1:0] grp, logic [2:0] rsel);
		cmd_valid && cmd_write && cmd_group == grp && cmd_reg == rsel;
	endsequence

	a_oper_cond_read: assert property (
		s_read(`GRP_OPER, `REG_COND) |=>
			rsp_valid && rsp_data == ($past(oper_cond_in) & `OPER_DEF_MASK))
		else $error("operation condition answer wrong");

	a_ques_cond_read: assert property (
		s_read(`GRP_QUES, `REG_COND) |=>
			rsp_valid && rsp_data[`QUES_POWER_BIT] == $past(sum_q[`GRP_POWER])
			&& rsp_data[`QUES_FREQ_BIT] == $past(freq_summary))
		else $error("questionable condition answer wrong");

	a_power_flags: assert property (
		s_read(`GRP_POWER, `REG_COND) |=>
			rsp_data[`PWR_RPP_BIT] == $past(rpp_tripped)
			&& rsp_data[`PWR_SRC_BIT] == $past(src_unleveled)
			&& rsp_data[`PWR_SRC_LO_BIT] == $past(src_lo_unleveled)
			&& rsp_data[`PWR_LO_BIT] == $past(lo_unleveled)
			&& rsp_data[`PWR_REF50_BIT] == $past(ref50_unleveled)
			&& rsp_data[`PWR_IN_OVL_BIT] == $past(input_ovl_tripped))
		else $error("power condition flags wrong");

	a_power_reserved: assert property (
		s_read(`GRP_POWER, `REG_COND) |=>
			(rsp_data & ~`PWR_DEF_MASK) == 16'h0000)
		else $error("power reserved bits not zero");

	a_lo_out_gate: assert property (
		s_read(`GRP_POWER, `REG_COND) |=>
			rsp_data[`PWR_LO_OUT_BIT] ==
			($past(lo_out_unleveled) && $past(ext_mix_fitted)))
		else $error("external mixing flag wrong");

	a_event_latch: assert property (
		1'b1 |=> (ev_q[`GRP_OPER] & $past(set_q[`GRP_OPER]))
			== $past(set_q[`GRP_OPER]))
		else $error("operation event not latched");

	a_ntr_event: assert property (
		$fell(cond_q[`GRP_POWER][`PWR_SRC_BIT]) && ntr_q[`GRP_POWER][`PWR_SRC_BIT]
			|=> ev_q[`GRP_POWER][`PWR_SRC_BIT])
		else $error("negative transition lost");

	a_event_clear: assert property (
		s_read(`GRP_POWER, `REG_EVENT) and (set_q[`GRP_POWER] == 16'h0000)
			|=> ev_q[`GRP_POWER] == 16'h0000
			&& rsp_data == $past(ev_q[`GRP_POWER]))
		else $error("event read did not clear");

	a_set_beats_clear: assert property (
		s_read(`GRP_QUES, `REG_EVENT) and (set_q[`GRP_QUES] != 16'h0000)
			|=> ev_q[`GRP_QUES] == $past(set_q[`GRP_QUES]))
		else $error("event lost during clearing read");

	a_enable_query: assert property (
		s_write(`GRP_OPER, `REG_ENABLE) ##1 !cmd_valid
			##1 s_read(`GRP_OPER, `REG_ENABLE) |=> rsp_data == $past(cmd_wdata, 3))
		else $error("enable query mismatch");

	a_oper_summary: assert property (
		s_write(`GRP_OPER, `REG_ENABLE) ##1
			((ev_q[`GRP_OPER] & $past(cmd_wdata)) != 16'h0000)
			|-> oper_summary)
		else $error("operation summary not raised");

	a_ques_summary: assert property (
		s_read(`GRP_QUES, `REG_EVENT) and (set_q[`GRP_QUES] == 16'h0000)
			|=> !ques_summary)
		else $error("questionable summary stuck");

	a_power_feed: assert property (
		$rose(sum_q[`GRP_POWER]) && ptr_q[`GRP_QUES][`QUES_POWER_BIT]
			|=> ev_q[`GRP_QUES][`QUES_POWER_BIT])
		else $error("power summary not propagated");

	a_freq_feed: assert property (
		$rose(freq_summary) && ptr_q[`GRP_QUES][`QUES_FREQ_BIT]
			|=> ev_q[`GRP_QUES][`QUES_FREQ_BIT])
		else $error("frequency summary not propagated");

	a_ques_sources: assert property (
		(cond_q[`GRP_QUES] & ~`QUES_DEF_MASK) == 16'h0000
			&& cond_q[`GRP_QUES][`QUES_POWER_BIT] == sum_q[`GRP_POWER])
		else $error("questionable condition from raw source");

	a_summary_live: assert property (
		s_write(`GRP_POWER, `REG_ENABLE) and (cmd_wdata == 16'h0000)
			|=> !sum_q[`GRP_POWER])
		else $error("summary not following enable");

	a_power_group: assert property (
		$rose(rpp_tripped) && ptr_q[`GRP_POWER][`PWR_RPP_BIT]
			&& en_q[`GRP_POWER][`PWR_RPP_BIT] |=> sum_q[`GRP_POWER])
		else $error("power group summary missing");

	a_prev_track: assert property (
		1'b1 |=> prev_q[`GRP_POWER] == $past(cond_q[`GRP_POWER]))
		else $error("previous condition not tracked");

	a_write_silent: assert property (
		cmd_valid && cmd_write |=> !rsp_valid)
		else $error("write produced an answer");

	a_ques_reserved: assert property (
		s_read(`GRP_QUES, `REG_COND) |=> (rsp_data & ~`QUES_DEF_MASK) == 16'h0000)
		else $error("questionable reserved bits not zero");

	a_ptr_write: assert property (
		s_write(`GRP_POWER, `REG_PTR) |=> ptr_q[`GRP_POWER] == $past(cmd_wdata))
		else $error("positive mask write lost");

	// Only a read of this group may drop an event bit
	a_event_hold: assert property (
		!(cmd_valid && !cmd_write && cmd_group == GRP_POWER_E
			&& cmd_reg == REG_EVENT_E)
			|=> (~ev_q[`GRP_POWER] & $past(ev_q[`GRP_POWER])) == 16'h0000)
		else $error("power event dropped without a read");

endmodule

// file: rtl/status_event_reporting_params.svh
// Constants of the status and event reporting block
`ifndef STATUS_EVENT_REPORTING_PARAMS_SVH
`define STATUS_EVENT_REPORTING_PARAMS_SVH

`define WORD_W         16
`define NUM_GRP        3

`define GRP_OPER       2'h0
`define GRP_QUES       2'h1
`define GRP_POWER      2'h2
`define GRP_NONE       2'h3

`define REG_COND       3'h0
`define REG_PTR        3'h1
`define REG_NTR        3'h2
`define REG_EVENT      3'h3
`define REG_ENABLE     3'h4

`define STB_OPER_BIT   7
`define STB_QUES_BIT   3

`define QUES_POWER_BIT 3
`define QUES_FREQ_BIT  5
`define QUES_CAL_BIT   8
`define QUES_INTEG_BIT 9

`define PWR_RPP_BIT    0
`define PWR_SRC_BIT    1
`define PWR_SRC_LO_BIT 2
`define PWR_LO_BIT     3
`define PWR_REF50_BIT  4
`define PWR_IN_OVL_BIT 6
`define PWR_LO_OUT_BIT 8

`define OPER_DEF_MASK  16'h7fff
`define QUES_DEF_MASK  16'h0328
`define PWR_DEF_MASK   16'h015f

`define PTR_RESET      16'hffff
`define NTR_RESET      16'h0000
`define ENABLE_RESET   16'h0000
`define EVENT_RESET    16'h0000
`define PREV_RESET     16'h0000
`define RSP_RESET      16'h0000

`endif

// file: verif/ctrl_model.sv
// Remote controller model that issues status commands and collects answers
`timescale 1ns/1ps

module ctrl_model
	import status_event_pkg::*;
(
	input  wire logic  clk,
	output logic       cmd_valid,
	output logic       cmd_write,
	output group_t     cmd_group,
	output reg_sel_t   cmd_reg,
	output word_t      cmd_wdata,
	input  wire logic  rsp_valid,
	input  wire word_t rsp_data
);
	initial begin
		cmd_valid = 1'b0;
		cmd_write = 1'b0;
		cmd_group = GRP_NONE_E;
		cmd_reg   = REG_COND_E;
		cmd_wdata = 16'h0000;
	end

	////////////////////////////////////////////////////////////////////////////
	// Released write and data lines flip so that a stale value never passes for a live one
	task automatic issue(input logic wr, input group_t g, input reg_sel_t r,
		input word_t w, output logic v, output word_t q);
		@(posedge clk);
		#1;
		cmd_valid = 1'b1;
		cmd_write = wr;
		cmd_group = g;
		cmd_reg   = r;
		cmd_wdata = w;
		@(posedge clk);
		#1;
		v = rsp_valid;
		q = rsp_data;
		cmd_valid = 1'b0;
		cmd_write = ~wr;
		cmd_wdata = ~w;
	endtask
endmodule

// file: verif/tb_top.sv
// Self-checking bench for the status and event reporting block
`timescale 1ns/1ps

module tb_top;
	import status_event_pkg::*;
	logic        clk          = 1'b0;
	logic        rst          = 1'b1;
	word_t       oper_cond_in = 16'h0000;
	logic [6:0]  pwr          = 7'h00;
	logic        ext_mix      = 1'b0;
	logic [2:0]  ques_src     = 3'h0;
	logic [31:0] seed         = 32'h000111ae;
	int          n_fail       = 0;
	int          n_tests      = 0;
	logic        cmd_valid;
	logic        cmd_write;
	group_t      cmd_group;
	reg_sel_t    cmd_reg;
	word_t       cmd_wdata;
	logic        rsp_valid;
	word_t       rsp_data;
	logic        oper_summary;
	logic        ques_summary;
	logic        v;
	word_t       d;
	word_t       w;

	always #20 clk = ~clk;

	ctrl_model ctrl_model_inst (.clk(clk), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
		.cmd_group(cmd_group), .cmd_reg(cmd_reg), .cmd_wdata(cmd_wdata),
		.rsp_valid(rsp_valid), .rsp_data(rsp_data));

	status_event_reporting status_event_reporting_inst (
		.clk(clk), .rst(rst), .oper_cond_in(oper_cond_in),
		.rpp_tripped(pwr[0]), .src_unleveled(pwr[1]), .src_lo_unleveled(pwr[2]),
		.lo_unleveled(pwr[3]), .ref50_unleveled(pwr[4]), .input_ovl_tripped(pwr[5]),
		.lo_out_unleveled(pwr[6]), .ext_mix_fitted(ext_mix), .freq_summary(ques_src[0]),
		.cal_summary(ques_src[1]), .integ_summary(ques_src[2]), .cmd_valid(cmd_valid),
		.cmd_write(cmd_write), .cmd_group(cmd_group), .cmd_reg(cmd_reg),
		.cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
		.oper_summary(oper_summary), .ques_summary(ques_summary));

	////////////////////////////////////////////////////////////////////////////
	function automatic word_t xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[15:0];
	endfunction

	// Bits 5, 7 and 9 to 15 stay zero; bit 8 needs external mixing
	function automatic word_t pwr_exp(logic [6:0] p, logic e);
		return {7'h00, p[6] & e, 1'b0, p[5], 1'b0, p[4:0]};
	endfunction

	task automatic check(string name, word_t seen, word_t exp);
		n_tests++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic tick(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic wr(group_t g, reg_sel_t r, word_t x);
		ctrl_model_inst.issue(1'b1, g, r, x, v, d);
	endtask

	task automatic rd(group_t g, reg_sel_t r, word_t e);
		ctrl_model_inst.issue(1'b0, g, r, 16'h0000, v, d);
		check("rsp_valid", {15'h0000, v}, 16'h0001);
		check("rsp_data", d, e);
	endtask

	task automatic report_and_stop();
		if (n_fail == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	initial begin
		repeat (5000) @(posedge clk);
		n_fail++;
		report_and_stop();
	end

	////////////////////////////////////////////////////////////////////////////
	initial begin
		tick(3);
		rst = 1'b0;
		for (int g = 0; g < 3; g++) begin
			rd(group_t'(g), REG_PTR_E, 16'hffff);
			rd(group_t'(g), REG_NTR_E, 16'h0000);
			rd(group_t'(g), REG_ENABLE_E, 16'h0000);
			for (int k = 0; k < 3; k++) begin
				w = xs();
				wr(group_t'(g), REG_ENABLE_E, w);
				rd(group_t'(g), REG_ENABLE_E, w);
			end
			wr(group_t'(g), REG_ENABLE_E, 16'h0000);
		end
		wr(GRP_POWER_E, REG_ENABLE_E, 16'h0001);
		// Condition writes must be ignored
		wr(GRP_POWER_E, REG_COND_E, 16'hffff);
		for (int i = 0; i < 7; i++) begin
			pwr = 7'h01 << i;
			tick(1);
			rd(GRP_POWER_E, REG_COND_E, pwr_exp(pwr, ext_mix));
		end
		pwr = 7'h7f;
		ext_mix = 1'b1;
		tick(1);
		rd(GRP_POWER_E, REG_COND_E, 16'h015f);
		rd(GRP_POWER_E, REG_EVENT_E, 16'h015f);
		rd(GRP_POWER_E, REG_EVENT_E, 16'h0000);
		wr(GRP_POWER_E, REG_PTR_E, 16'h0000);
		wr(GRP_POWER_E, REG_NTR_E, 16'h0002);
		wr(GRP_POWER_E, REG_ENABLE_E, 16'h0002);
		wr(GRP_QUES_E, REG_ENABLE_E, 16'h0008);
		pwr = 7'h00;
		tick(3);
		check("ques_summary", {15'h0000, ques_summary}, 16'h0001);
		rd(GRP_QUES_E, REG_COND_E, 16'h0008);
		rd(GRP_POWER_E, REG_EVENT_E, 16'h0002);
		rd(GRP_QUES_E, REG_COND_E, 16'h0000);
		rd(GRP_QUES_E, REG_EVENT_E, 16'h0008);
		check("ques_summary", {15'h0000, ques_summary}, 16'h0000);
		ques_src = 3'h7;
		tick(1);
		rd(GRP_QUES_E, REG_COND_E, 16'h0320);
		ques_src = 3'h0;
		tick(1);
		// Frequency summary rises at the very edge that takes the clearing read
		fork
			ctrl_model_inst.issue(1'b0, GRP_QUES_E, REG_EVENT_E, 16'h0000, v, d);
			begin
				@(posedge clk);
				#1;
				ques_src = 3'h1;
			end
		join
		check("ques_event", d, 16'h0320);
		rd(GRP_QUES_E, REG_EVENT_E, 16'h0020);
		for (int k = 0; k < 8; k++) begin
			oper_cond_in = xs();
			tick(1);
			rd(GRP_OPER_E, REG_COND_E, oper_cond_in & 16'h7fff);
		end
		oper_cond_in = 16'h0000;
		wr(GRP_OPER_E, REG_ENABLE_E, 16'h0200);
		ctrl_model_inst.issue(1'b0, GRP_OPER_E, REG_EVENT_E, 16'h0000, v, d);
		oper_cond_in = 16'h0008;
		tick(2);
		check("oper_summary", {15'h0000, oper_summary}, 16'h0000);
		oper_cond_in = 16'h0208;
		tick(2);
		check("oper_summary", {15'h0000, oper_summary}, 16'h0001);
		rd(GRP_NONE_E, REG_COND_E, 16'h0000);
		report_and_stop();
	end
endmodule
